// ==== logic/sadc_top.sv ====
// Serial interface and conversion sequencer of an 8-channel 10-bit converter.
// Assumes analog mux, capacitor DAC and comparator sit outside; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module sadc_top
  import sadc_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  output logic conversion_strobe_out,
  output logic conversion_strobe_oe,
  // Analog front end
  input wire logic cmp_keep,
  output logic [2:0] pos_chan,
  output logic [2:0] neg_chan,
  output logic neg_to_ground,
  output logic track_hold_track,
  output logic sampling_capacitor_to_pos,
  output logic [RES_BITS-1:0] dac_trial,
  // Status
  output logic [RES_BITS-1:0] result,
  output logic [1:0] power_mode,
  output logic polarity_select,
  output logic input_mode_select,
  output logic busy
);
  function automatic logic [RES_BITS-1:0] sar_step(input logic [RES_BITS-1:0] code,
                                                   input logic [3:0] idx,
                                                   input logic keep);
    logic [RES_BITS-1:0] nxt;
    nxt = code;
    nxt[idx] = keep;
    if (idx != 4'h0) begin
      nxt[idx - 4'h1] = 1'b1;
    end
    return nxt;
  endfunction

  logic [3:0] pins_sync;
  logic sclk_s;
  logic cs_n_s;
  logic din_s;
  logic cmp_s;
  logic sclk_d;
  sadc_state_t state;
  logic [CTRL_BITS-1:0] ctrl_sh;
  logic [3:0] bit_cnt;
  logic [3:0] step_idx;
  logic [7:0] step_timer;
  logic [RES_BITS-1:0] out_sh;
  logic ext_mode;
  logic [2:0] sel_code;

  // Every pin, comparator included, is resampled twice before use
  sadc_sync #(.WIDTH(4), .RESET_VAL(PIN_SYNC_RESET)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({sclk, cs_n, din, cmp_keep}),
    .sync_out(pins_sync)
  );

  assign sclk_s = pins_sync[3];
  assign cs_n_s = pins_sync[2];
  assign din_s = pins_sync[1];
  assign cmp_s = pins_sync[0];

  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;
  wire selected = ~cs_n_s;
  wire shift_rise = sclk_rise & selected;
  wire shift_fall = sclk_fall & selected;
  wire ctrl_done = shift_fall && state == SADC_SHIFT && bit_cnt == HOLD_AFTER_BIT;
  wire [1:0] ctrl_mode = {ctrl_sh[POS_MODE_HI], ctrl_sh[POS_MODE_LO]};
  wire step_due = state == SADC_INT_CONV && step_timer == 8'h01;
  wire [RES_BITS-1:0] int_next = sar_step(dac_trial, step_idx, cmp_s);
  wire [RES_BITS-1:0] ext_next = sar_step(dac_trial, step_idx, cmp_s);
  // Mode high bit still sits in the lowest place at the eighth rise
  wire ext_pulse_prep = shift_rise && state == SADC_SHIFT && bit_cnt == HOLD_AFTER_BIT - 4'h1
                        && {ctrl_sh[POS_MODE_LO], din_s} == MODE_EXT_CLK;

  // Channel index order follows the select code as {mid, lo, hi}
  assign pos_chan = {sel_code[1], sel_code[0], sel_code[2]};
  assign neg_chan = {sel_code[1], sel_code[0], ~sel_code[2]};
  assign neg_to_ground = input_mode_select;

  // dout floats whenever chip select is high; the strobe does so only in external-clock mode
  assign dout_oe = selected;
  assign conversion_strobe_oe = ext_mode ? selected : 1'b1;
  assign busy = state == SADC_EXT_CONV || state == SADC_INT_CONV;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  // Sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= SADC_IDLE;
      ctrl_sh <= '0;
      bit_cnt <= 4'h0;
    end else if (cs_n_s && state != SADC_INT_CONV) begin
      // Internal conversions survive a deselect; everything else restarts
      state <= SADC_IDLE;
      ctrl_sh <= '0;
      bit_cnt <= 4'h0;
    end else if (shift_rise && (state == SADC_IDLE || state == SADC_READOUT)) begin
      if (din_s) begin
        ctrl_sh <= {{(CTRL_BITS-1){1'b0}}, 1'b1};
        bit_cnt <= 4'h1;
        state <= SADC_SHIFT;
      end
    end else if (shift_rise && state == SADC_SHIFT && bit_cnt != HOLD_AFTER_BIT) begin
      ctrl_sh <= {ctrl_sh[CTRL_BITS-2:0], din_s};
      bit_cnt <= bit_cnt + 4'h1;
    end else if (ctrl_done) begin
      unique case (ctrl_mode)
        MODE_EXT_CLK: state <= SADC_EXT_CONV;
        MODE_INT_CLK: state <= SADC_INT_CONV;
        MODE_FULL_PD, MODE_FAST_PD: state <= SADC_IDLE;
      endcase
    end else if (state == SADC_EXT_CONV && shift_fall && !conversion_strobe_out
                 && step_idx == 4'h0) begin
      state <= SADC_IDLE;
    end else if (step_due && step_idx == 4'h0) begin
      state <= SADC_READOUT;
    end
  end

  // Latched control fields and track/hold switching
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_code <= 3'h0;
      polarity_select <= 1'b1;
      input_mode_select <= 1'b1;
      power_mode <= MODE_RESET;
      ext_mode <= 1'b0;
      track_hold_track <= 1'b0;
    end else if (shift_fall && state == SADC_SHIFT && bit_cnt == TRACK_AFTER_BIT) begin
      track_hold_track <= 1'b1;
    end else if (ctrl_done) begin
      track_hold_track <= 1'b0;
      sel_code <= {ctrl_sh[POS_SEL_HI], ctrl_sh[POS_SEL_MID], ctrl_sh[POS_SEL_LO]};
      polarity_select <= ctrl_sh[POS_POLARITY];
      input_mode_select <= ctrl_sh[POS_INPUT_MODE];
      power_mode <= ctrl_mode;
      ext_mode <= ctrl_mode == MODE_EXT_CLK;
    end
  end

  // Successive approximation and strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dac_trial <= '0;
      step_idx <= 4'h0;
      step_timer <= 8'h0;
      result <= '0;
      conversion_strobe_out <= 1'b1;
      sampling_capacitor_to_pos <= 1'b1;
    end else if (ctrl_done && ctrl_mode[1]) begin
      dac_trial <= SAR_FIRST_TRIAL;
      step_idx <= 4'(RES_BITS - 1);
      step_timer <= INT_STEP_CYC;
      sampling_capacitor_to_pos <= 1'b0;
      conversion_strobe_out <= ctrl_mode == MODE_EXT_CLK;
    end else if (ext_pulse_prep) begin
      // Low first, so the external pulse has a rising edge
      conversion_strobe_out <= 1'b0;
    end else if (state == SADC_EXT_CONV && shift_fall) begin
      if (conversion_strobe_out) begin
        conversion_strobe_out <= 1'b0;
      end
      dac_trial <= ext_next;
      if (step_idx == 4'h0) begin
        result <= ext_next;
        sampling_capacitor_to_pos <= 1'b1;
      end else begin
        step_idx <= step_idx - 4'h1;
      end
    end else if (state == SADC_EXT_CONV && cs_n_s) begin
      // Deselect aborts an external-clock conversion
      sampling_capacitor_to_pos <= 1'b1;
      conversion_strobe_out <= 1'b0;
    end else if (state == SADC_INT_CONV) begin
      step_timer <= step_due ? INT_STEP_CYC : step_timer - 8'h01;
      if (step_due) begin
        dac_trial <= int_next;
        if (step_idx == 4'h0) begin
          result <= int_next;
          conversion_strobe_out <= 1'b1;
          sampling_capacitor_to_pos <= 1'b1;
        end else begin
          step_idx <= step_idx - 4'h1;
        end
      end
    end
  end

  // Serial result output, MSB first, zeros after the LSB
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dout <= 1'b0;
      out_sh <= '0;
    end else if (step_due && step_idx == 4'h0) begin
      dout <= int_next[RES_BITS-1];
      out_sh <= {int_next[RES_BITS-2:0], 1'b0};
    end else if (shift_fall && state == SADC_EXT_CONV) begin
      // Each decision goes out as it is made, MSB at the strobe's fall
      dout <= cmp_s;
      out_sh <= '0;
    end else if (shift_fall) begin
      dout <= out_sh[RES_BITS-1];
      out_sh <= {out_sh[RES_BITS-2:0], 1'b0};
    end
  end
endmodule
`default_nettype wire

// ==== logic/sadc_pkg.sv ====
// Constants shared by the serial converter interface and sequencer.
// Assumes a 10 MHz system clock that oversamples the serial pins.
package sadc_pkg;
  localparam int RES_BITS = 10;
  localparam int CTRL_BITS = 8;
  localparam logic [3:0] TRACK_AFTER_BIT = 4'h5;
  localparam logic [3:0] HOLD_AFTER_BIT = 4'h8;
  // Control byte field positions
  localparam int POS_SEL_HI = 6;
  localparam int POS_SEL_MID = 5;
  localparam int POS_SEL_LO = 4;
  localparam int POS_POLARITY = 3;
  localparam int POS_INPUT_MODE = 2;
  localparam int POS_MODE_HI = 1;
  localparam int POS_MODE_LO = 0;
  // Mode encodings
  localparam logic [1:0] MODE_FULL_PD = 2'h0;
  localparam logic [1:0] MODE_FAST_PD = 2'h1;
  localparam logic [1:0] MODE_INT_CLK = 2'h2;
  localparam logic [1:0] MODE_EXT_CLK = 2'h3;
  // Reset values and the first SAR trial code
  localparam logic [1:0] MODE_RESET = MODE_FULL_PD;
  // Pin idle levels in sync order {sclk, cs_n, din, cmp}: no false select after reset
  localparam logic [3:0] PIN_SYNC_RESET = 4'h4;
  localparam logic [RES_BITS-1:0] SAR_FIRST_TRIAL = 10'h200;
  // Internal conversion clock: one approximation step per period
  localparam int CLK_PERIOD_NS = 100;
  localparam int INT_STEP_NS = 1000;
  localparam int INT_STEP_CYC_I = (INT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] INT_STEP_CYC = INT_STEP_CYC_I[7:0];
  typedef enum logic [2:0] {SADC_IDLE, SADC_SHIFT, SADC_EXT_CONV, SADC_INT_CONV,
    SADC_READOUT} sadc_state_t;
endpackage

// ==== logic/sadc_sync.sv ====
// Two-stage synchroniser for pins that arrive from outside the clock domain.
// Assumes each bit is an independent level; no multi-bit coherence is given.
`timescale 1ns/1ps
`default_nettype none
module sadc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/sadc_checker.sv ====
// Port-level assertions for the converter serial sequencer.
// Assumes a slow host: every pin level lasts several system clocks.
`timescale 1ns/1ps
`default_nettype none
module sadc_checker
  import sadc_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Serial pins
  input wire logic cs_n,
  input wire logic dout_oe,
  input wire logic conversion_strobe_out,
  input wire logic conversion_strobe_oe,
  // Front end and status
  input wire logic [2:0] pos_chan,
  input wire logic [2:0] neg_chan,
  input wire logic neg_to_ground,
  input wire logic track_hold_track,
  input wire logic sampling_capacitor_to_pos,
  input wire logic [1:0] power_mode,
  input wire logic input_mode_select,
  input wire logic busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Four cycles cover the pin synchroniser delay
  dout_float_a: assert property (cs_n [*4] |-> !dout_oe)
    else $error("dout driven while deselected");
  strobe_float_a: assert property ((cs_n && power_mode == MODE_EXT_CLK) [*4] |->
    !conversion_strobe_oe) else $error("strobe driven while deselected");
  strobe_drive_a: assert property (power_mode != MODE_EXT_CLK |-> conversion_strobe_oe)
    else $error("strobe not driven in internal mode");
  no_shift_a: assert property (cs_n [*4] |=> $stable(power_mode))
    else $error("control byte taken while deselected");
  se_ground_a: assert property (input_mode_select |-> neg_to_ground)
    else $error("negative input not grounded");
  diff_pair_a: assert property (!input_mode_select |->
    !neg_to_ground && neg_chan == (pos_chan ^ 3'h1)) else $error("bad input pair");
  int_strobe_a: assert property (busy && power_mode == MODE_INT_CLK |->
    !conversion_strobe_out) else $error("strobe high during conversion");
  ext_pulse_a: assert property ($rose(conversion_strobe_out) && power_mode == MODE_EXT_CLK
    |-> conversion_strobe_out [*6] ##[1:4] !conversion_strobe_out)
    else $error("strobe pulse not one serial period");
  acq_window_a: assert property ($rose(track_hold_track) |->
    track_hold_track [*8] ##[14:20] !track_hold_track) else $error("acquisition length");
  cap_back_a: assert property ($fell(busy) |-> sampling_capacitor_to_pos)
    else $error("capacitor not reconnected");
  hold_conv_a: assert property (busy |-> !track_hold_track)
    else $error("tracking during conversion");
endmodule
bind sadc_top sadc_checker i_chk (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n),
  .dout_oe(dout_oe), .conversion_strobe_out(conversion_strobe_out),
  .conversion_strobe_oe(conversion_strobe_oe), .pos_chan(pos_chan), .neg_chan(neg_chan),
  .neg_to_ground(neg_to_ground), .track_hold_track(track_hold_track),
  .sampling_capacitor_to_pos(sampling_capacitor_to_pos), .power_mode(power_mode),
  .input_mode_select(input_mode_select), .busy(busy));
`default_nettype wire

// ==== testbench/sadc_host.sv ====
// Host serial master model: 800 ns serial clock, idle low.
// Assumes the bench calls its tasks from the system clock's falling edge.
`timescale 1ns/1ps
`default_nettype none
module sadc_host (
  // System
  input wire logic clk,
  // Serial pins
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  logic [31:0] rx = '0;
  logic last = 1'b0;
  logic line;
  // No pull on dout: a floating line reads as the inverse
  assign line = dout_oe ? dout : ~last;
  always @(posedge clk) if (dout_oe) last <= dout;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  task automatic select(input logic on);
    repeat (4) @(negedge clk);
    cs_n = !on;
    din = ~din;
    repeat (4) @(negedge clk);
  endtask
  // Three 800 ns periods of acquisition exceed 1.5 us
  task automatic shift(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      din = v[i];
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      rx = {rx[30:0], line};
      sclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== testbench/sadc_top_tb.sv ====
// Self-checking bench for the converter serial sequencer.
// Assumes a comparator model keeping each trial at or below vin.
`timescale 1ns/1ps
`default_nettype none
module sadc_top_tb
  import sadc_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst, sclk, cs_n, din, dout, dout_oe, conversion_strobe_out;
  logic conversion_strobe_oe, cmp_keep, neg_to_ground, track_hold_track;
  logic sampling_capacitor_to_pos, polarity_select, input_mode_select, busy;
  logic [2:0] pos_chan, neg_chan, pos;
  logic [9:0] dac_trial, result, vin;
  logic [1:0] power_mode;
  logic [7:0] b;
  int num_errors = 0;
  int n_checks = 0;
  always #50 clk = ~clk;
  always @(negedge clk) cmp_keep <= (dac_trial <= vin);
  sadc_top i_dut (.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .dout_oe(dout_oe), .conversion_strobe_out(conversion_strobe_out),
    .conversion_strobe_oe(conversion_strobe_oe), .cmp_keep(cmp_keep), .pos_chan(pos_chan),
    .neg_chan(neg_chan), .neg_to_ground(neg_to_ground), .track_hold_track(track_hold_track),
    .sampling_capacitor_to_pos(sampling_capacitor_to_pos), .dac_trial(dac_trial),
    .result(result), .power_mode(power_mode), .polarity_select(polarity_select),
    .input_mode_select(input_mode_select), .busy(busy));
  sadc_host i_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .dout_oe(dout_oe));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    sys_rst = 1'b1;
    vin = 10'h000;
    // Two edges; the synchronisers reset to the pin idle levels
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    chk("reset", 17'h0001B, {result, power_mode, polarity_select, input_mode_select,
      track_hold_track, sampling_capacitor_to_pos, conversion_strobe_out});
    for (int i = 0; i < 16; i++) begin
      b = {1'b1, i[2:0], 1'b1, i[3], 1'b0, i[0]};
      pos = {b[5], b[4], b[6]};
      i_host.select(1'b1);
      i_host.shift({24'h0, b}, 8);
      i_host.select(1'b0);
      chk("mux", {pos, b[2], b[1:0]}, {pos_chan, neg_to_ground, power_mode});
      if (!b[2]) chk("neg", pos ^ 3'h1, neg_chan);
    end
    // Aborted byte, then ones clocked while deselected
    i_host.select(1'b1);
    i_host.shift(32'h6, 3);
    i_host.select(1'b0);
    i_host.shift(32'hFF, 6);
    i_host.select(1'b1);
    i_host.shift(32'h8D, 8);
    i_host.select(1'b0);
    chk("abort", 7'h07, {pos_chan, power_mode, polarity_select, input_mode_select});
    vin = 10'h2A5;
    i_host.select(1'b1);
    i_host.shift({3'h0, 8'hF7, 11'h0}, 22);
    i_host.select(1'b0);
    chk("ext dout", vin, i_host.rx[9:0]);
    chk("ext result", {vin, 3'h7, 1'b0}, {result, pos_chan, polarity_select});
    chk("released", 2'h0, {dout_oe, conversion_strobe_oe});
    vin = 10'h15A;
    i_host.select(1'b1);
    i_host.shift(32'hAE, 8);
    i_host.select(1'b0);
    chk("int start", 3'h5, {busy, conversion_strobe_out, conversion_strobe_oe});
    for (int k = 0; k < 300 && busy !== 1'b0; k++) @(negedge clk);
    if (busy !== 1'b0) begin
      num_errors++;
      $display("CHECK FAILED busy expected 0 seen %b", busy);
    end else begin
      chk("int end", {vin, 2'h3},
        {result, conversion_strobe_out, sampling_capacitor_to_pos});
      i_host.select(1'b1);
      i_host.shift(32'h0, 10);
      i_host.select(1'b0);
      chk("int dout", vin, i_host.rx[9:0]);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
